// ==== bench/owc_checker.sv ====
// owc_checker: port-level assertions for the single-wire command engine
`timescale 1ns/1ps
module owc_checker #(
  parameter logic [19:0] RSTL_DEFAULT = 20'h00190
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_out,
  input wire logic line_oe
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [3:0] since_wr;
  logic [19:0] oe_run;
  // write age saturates so a stale write never excuses a late start
  always_ff @(posedge clk) begin
    if (!reset_n || (s_axi_wvalid && s_axi_wready)) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hf) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  // length of the current low drive
  always_ff @(posedge clk) begin
    if (!reset_n || !line_oe) begin
      oe_run <= 20'h00000;
    end else begin
      oe_run <= oe_run + 20'h00001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence low_start;
    $rose(line_oe);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_line_low_only: assert property (line_oe |-> !line_out)
    else $error("line driven high");
  a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_start_prompt: assert property (low_start |-> since_wr <= 4'h4)
    else $error("line activity without prompt command");
  a_low_bounded: assert property (oe_run <= RSTL_DEFAULT)
    else $error("low drive longer than reset low time");
  a_low_min: assert property (low_start |=> line_oe [*8])
    else $error("low drive too short");
endmodule
bind owc_top owc_checker #(.RSTL_DEFAULT(RSTL_DEFAULT)) i_chk (.clk(clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_out(line_out), .line_oe(line_oe));

// ==== bench/owc_slave_model.sv ====
// owc_slave_model: behavioural slave on the single-wire line
`timescale 1ns/1ps
module owc_slave_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_oe,
  input wire logic present,
  input wire logic short_on,
  input wire logic rd_bit,
  output logic slave_low
);
  logic oe_q;
  logic [9:0] low_run;
  logic [9:0] pres_t;
  logic [9:0] slot_t;
  // presence begins after the short-sample point so a healthy slave is not seen as a short
  always_ff @(posedge clk) begin
    oe_q <= line_oe && reset_n;
    low_run <= (line_oe && !oe_q) ? 10'h000 : low_run + {9'h000, line_oe};
    if (!reset_n) begin
      pres_t <= 10'h3ff;
    end else if (oe_q && !line_oe && low_run >= 10'h12c) begin
      pres_t <= 10'h000;
    end else if (pres_t != 10'h3ff) begin
      pres_t <= pres_t + 10'h001;
    end
    if (!reset_n) begin
      slot_t <= 10'h3ff;
    end else if (line_oe && !oe_q) begin
      slot_t <= 10'h000;
    end else if (slot_t != 10'h3ff) begin
      slot_t <= slot_t + 10'h001;
    end
  end
  // a zero bit holds the line past the bit-sample point
  assign slave_low = short_on || (present && pres_t >= 10'h096 && pres_t < 10'h15e) ||
    (!rd_bit && slot_t < 10'h118);
endmodule

// ==== bench/tb_top.sv ====
// tb_top: self-checking bench for the single-wire command engine
`timescale 1ns/1ps
module tb_top;
  localparam logic [19:0] RSTL = 20'h00190;
  logic clk = 1'b0, reset_n = 1'b0, present = 1'b0, short_on = 1'b0, rd_bit = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_out, line_oe, slave_low;
  logic strong_pullup_enable, active_pullup_enable, pick, od, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [19:0] run = 20'h0, last_len = 20'h0;
  int pulses = 0, errors = 0, checked = 0, cyc = 0;
  wire line_in = !(line_oe || slave_low);
  owc_top #(.RSTL_DEFAULT(RSTL), .MSP_DEFAULT(20'h000c8), .W0L_DEFAULT(20'h0012c), .REC0_DEFAULT(20'h00014)) i_dut (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .strong_pullup_on(strong_pullup_enable), .active_pullup_on(active_pullup_enable),
    .pullup_pick_out(pick), .overdrive_on(od), .irq(irq));
  owc_slave_model i_slave (.clk(clk), .reset_n(reset_n), .line_oe(line_oe), .present(present),
    .short_on(short_on), .rd_bit(rd_bit), .slave_low(slave_low));
  always #4 clk = ~clk;
  // low-pulse monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    run <= line_oe ? run + 20'h1 : 20'h0;
    if (!line_oe && run != 20'h0) begin
      last_len <= run;
      pulses <= pulses + 1;
    end
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // bus master: valid and payload held until each ready; bready follows bvalid so the hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_idle(input int t0, output int el);
    logic [31:0] d;
    logic [1:0] r;
    do rd(owc_pkg::ADDR_STATUS, d, r); while (d[owc_pkg::ST_BUSY] !== 1'b0);
    el = cyc - t0;
  endtask
  // reset values, config outputs, bad address and bad code
  task automatic t_config();
    logic [31:0] d;
    logic [1:0] r;
    rd(owc_pkg::ADDR_POINTED, d, r);
    chk(d, 32'h0, "config after reset");
    rd(8'h30, d, r);
    chk({30'h0, r}, {30'h0, owc_pkg::RESP_SLVERR}, "unmapped read");
    wr(owc_pkg::ADDR_CONFIG, 32'h0000000d, r);
    rd(owc_pkg::ADDR_CONFIG, d, r);
    chk(d, 32'h0000000d, "config readback");
    chk({28'h0, strong_pullup_enable, active_pullup_enable, pick, od}, 32'h7, "config outputs");
    wr(owc_pkg::ADDR_COMMAND, 32'h00000096, r);
    chk({30'h0, r}, {30'h0, owc_pkg::RESP_SLVERR}, "foreign code");
    chk(pulses, 32'h0, "no line activity");
  endtask
  task automatic t_line_reset(input logic pres, input logic shrt, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    int p0, t0, el;
    present <= pres;
    short_on <= shrt;
    p0 = pulses;
    t0 = cyc;
    wr(owc_pkg::ADDR_COMMAND, 32'h000000b4, r);
    chk({30'h0, r}, 32'h0, "reset accepted");
    rd(owc_pkg::ADDR_POINTED, d, r);
    chk(d & 32'h1, 32'h1, "pointer at busy status");
    wr(owc_pkg::ADDR_COMMAND, 32'h000000b4, r);
    chk({30'h0, r}, {30'h0, owc_pkg::RESP_SLVERR}, "reset while busy");
    wr(owc_pkg::ADDR_COMMAND, 32'h00008087, r);
    chk({30'h0, r}, {30'h0, owc_pkg::RESP_SLVERR}, "slot while busy");
    wait_idle(t0, el);
    chk(32'(el >= 796 && el <= 830), 32'h1, "busy span");
    chk(32'(last_len), 32'(RSTL), "reset low length");
    chk(pulses - p0, 32'h1, "single low pulse");
    rd(owc_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h6, exp, "presence and short");
    short_on <= 1'b0;
  endtask
  task automatic t_slot(input logic bitv, input logic sb, input logic [19:0] len, input logic exp, input int span);
    logic [31:0] d;
    logic [1:0] r;
    int p0, t0, el;
    rd_bit <= sb;
    p0 = pulses;
    t0 = cyc;
    wr(owc_pkg::ADDR_COMMAND, {16'h0, bitv, 7'h55, 8'h87}, r);
    chk({30'h0, r}, 32'h0, "slot accepted");
    rd(owc_pkg::ADDR_POINTED, d, r);
    chk(d & 32'h1, 32'h1, "pointer at busy status");
    wait_idle(t0, el);
    chk(32'(el >= span - 4 && el <= span + 30), 32'h1, "slot span");
    chk(32'(last_len), 32'(len), "slot low length");
    chk(pulses - p0, 32'h1, "one slot");
    rd(owc_pkg::ADDR_STATUS, d, r);
    chk(32'(d[owc_pkg::ST_BIT]), 32'(exp), "sampled bit");
  endtask
  // masked, unmasked, then cleared interrupt
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    chk(32'(irq), 32'h0, "masked irq");
    wr(owc_pkg::ADDR_INT_MASK, 32'h7, r);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "unmasked irq");
    rd(owc_pkg::ADDR_INT_STATUS, d, r);
    chk(d, 32'h7, "events seen");
    wr(owc_pkg::ADDR_INT_STATUS, 32'h7, r);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "cleared irq");
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_config();
    t_line_reset(1'b1, 1'b0, 32'h2);
    t_line_reset(1'b0, 1'b0, 32'h0);
    t_line_reset(1'b1, 1'b1, 32'h6);
    t_slot(1'b0, 1'b1, 20'h0012c, 1'b0, 320);
    t_slot(1'b1, 1'b1, owc_pkg::W1L_OD_CYC, 1'b1, 320);
    t_slot(1'b1, 1'b0, owc_pkg::W1L_OD_CYC, 1'b0, 320);
    // a rewritten zero-low time must shape the very next slot; kept below the model's presence trigger
    wr(owc_pkg::ADDR_W0L, 32'h00000118, r);
    chk({30'h0, r}, 32'h0, "timing write");
    rd(owc_pkg::ADDR_W0L, d, r);
    chk(d, 32'h00000118, "timing readback");
    t_slot(1'b0, 1'b1, 20'h00118, 1'b0, 300);
    t_irq();
    conclude();
  end
endmodule

// ==== logic/owc_pkg.sv ====
// owc_pkg: constants shared by the single-wire command engine
package owc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int START_DELAY_PS = 262500;
  localparam int START_DELAY_CYC = START_DELAY_PS / (CLK_NS * 1000);
  localparam int RSTL_STD_NS = 560000;
  localparam int MSP_STD_NS = 68000;
  localparam int W0L_STD_NS = 64000;
  localparam int REC0_STD_NS = 5250;
  localparam int RSTL_STD_CYC = (RSTL_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MSP_STD_CYC = (MSP_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int W0L_STD_CYC = (W0L_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC0_STD_CYC = (REC0_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int W1L_STD_NS = 8000;
  localparam int W1L_OD_NS = 1000;
  localparam int MSR_STD_NS = 14000;
  localparam int MSR_OD_NS = 2000;
  localparam int SI_STD_NS = 8000;
  localparam int SI_OD_NS = 1000;
  localparam logic [19:0] W1L_STD_CYC = 20'((W1L_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] W1L_OD_CYC = 20'((W1L_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] MSR_STD_CYC = 20'((MSR_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] MSR_OD_CYC = 20'((MSR_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] SI_STD_CYC = 20'((SI_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [19:0] SI_OD_CYC = 20'((SI_OD_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_POINTED = 8'h0c;
  localparam logic [7:0] ADDR_RSTL = 8'h10;
  localparam logic [7:0] ADDR_MSP = 8'h14;
  localparam logic [7:0] ADDR_W0L = 8'h18;
  localparam logic [7:0] ADDR_REC0 = 8'h1c;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h24;
  // command codes
  localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
  localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
  localparam int PARAM_BIT_POS = 15;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_PRESENCE = 1;
  localparam int ST_SHORT = 2;
  localparam int ST_BIT = 3;
  localparam int ST_BRANCH = 5;
  // config fields and reset value
  localparam int CF_APU = 0;
  localparam int CF_SPU = 1;
  localparam int CF_OD = 2;
  localparam int CF_PICK = 3;
  localparam logic [3:0] CONFIG_RESET = 4'h0;
  // interrupt events
  localparam int EV_RESET_DONE = 0;
  localparam int EV_SLOT_DONE = 1;
  localparam int EV_SHORT = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // sequencer states
  typedef enum logic [1:0] {
    OWC_IDLE = 2'b00,
    OWC_RST_LOW = 2'b01,
    OWC_RST_HIGH = 2'b10,
    OWC_SLOT = 2'b11
  } owc_state_type;
endpackage

// ==== logic/owc_top.sv ====
// owc_top: reset/presence and single-slot engine with AXI4-Lite registers
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - code b4h drives reset low, then presence window
// - sample short and presence, report status flags
// - reset refused while busy, no line activity
// - reset starts promptly, lasts two reset times
// - accepted reset points read pointer at status
// - busy two reset times; flags at sample times
// - waveforms use current speed, pullup, timing settings
// - code 87h with parameter makes one slot
// - bit zero writes zero; one writes/reads
// - sample line at bit-sample time into result
// - single-slot command refused while busy
// - slot starts promptly, completes within slot time
// - single-slot command points read pointer at status
// - busy one slot; result at sample time
module owc_top #(
  parameter logic [19:0] RSTL_DEFAULT = 20'(owc_pkg::RSTL_STD_CYC),
  parameter logic [19:0] MSP_DEFAULT = 20'(owc_pkg::MSP_STD_CYC),
  parameter logic [19:0] W0L_DEFAULT = 20'(owc_pkg::W0L_STD_CYC),
  parameter logic [19:0] REC0_DEFAULT = 20'(owc_pkg::REC0_STD_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic strong_pullup_on,
  output logic active_pullup_on,
  output logic pullup_pick_out,
  output logic overdrive_on,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  owc_pkg::owc_state_type state;
  logic [19:0] cnt;
  logic slot_bit;
  logic line_busy_flag;
  logic presence_pulse_detected;
  logic short_detected;
  logic single_bit_result;
  logic [3:0] config_bits;
  logic [19:0] rstl_cyc;
  logic [19:0] msp_cyc;
  logic [19:0] w0l_cyc;
  logic [19:0] rec0_cyc;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [7:0] read_ptr;
  logic aw_full;
  logic w_full;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire wr_lane0 = do_write && wr_strb[0];
  wire wr_cmd = wr_lane0 && (wr_addr == owc_pkg::ADDR_COMMAND);
  wire [7:0] cmd_code = wr_data[7:0];
  // a busy engine refuses both commands outright
  wire start_reset = wr_cmd && (cmd_code == owc_pkg::CMD_LINE_RESET) && !line_busy_flag;
  wire start_bit = wr_cmd && (cmd_code == owc_pkg::CMD_SINGLE_BIT) && wr_strb[1]
                   && !line_busy_flag;
  wire cmd_taken = start_reset || start_bit;
  wire wr_cfg = wr_lane0 && (wr_addr == owc_pkg::ADDR_CONFIG);
  wire wr_rstl = do_write && (wr_addr == owc_pkg::ADDR_RSTL);
  wire wr_msp = do_write && (wr_addr == owc_pkg::ADDR_MSP);
  wire wr_w0l = do_write && (wr_addr == owc_pkg::ADDR_W0L);
  wire wr_rec0 = do_write && (wr_addr == owc_pkg::ADDR_REC0);
  wire wr_iclr = wr_lane0 && (wr_addr == owc_pkg::ADDR_INT_STATUS);
  wire wr_imask = wr_lane0 && (wr_addr == owc_pkg::ADDR_INT_MASK);
  wire wr_mapped = (wr_addr == owc_pkg::ADDR_CONFIG) || (wr_addr == owc_pkg::ADDR_RSTL) ||
                   (wr_addr == owc_pkg::ADDR_MSP) || (wr_addr == owc_pkg::ADDR_W0L) ||
                   (wr_addr == owc_pkg::ADDR_REC0) || (wr_addr == owc_pkg::ADDR_INT_STATUS) ||
                   (wr_addr == owc_pkg::ADDR_INT_MASK);
  // a refused command answers slverr, the bus form of a missing acknowledge
  wire [1:0] wr_resp = (cmd_taken || (wr_mapped && !wr_cmd)) ? owc_pkg::RESP_OKAY : owc_pkg::RESP_SLVERR;
  // timing registers take full 20-bit counts, lanes 0..2
  wire [19:0] wr_count = {wr_data[19:16], wr_data[15:0]};

  // ----------------------------------------------------------------
  // timing selection from current settings
  // ----------------------------------------------------------------
  wire od = config_bits[owc_pkg::CF_OD];
  wire [19:0] w1l_cyc = od ? owc_pkg::W1L_OD_CYC : owc_pkg::W1L_STD_CYC;
  wire [19:0] msr_cyc = od ? owc_pkg::MSR_OD_CYC : owc_pkg::MSR_STD_CYC;
  wire [19:0] si_cyc = od ? owc_pkg::SI_OD_CYC : owc_pkg::SI_STD_CYC;
  wire [19:0] low_cyc = slot_bit ? w1l_cyc : w0l_cyc;
  wire [19:0] slot_cyc = w0l_cyc + rec0_cyc;
  wire cnt_last_rst = (cnt == rstl_cyc - 20'h00001);
  wire cnt_last_slot = (cnt == slot_cyc - 20'h00001);
  wire hit_short = (state == owc_pkg::OWC_RST_HIGH) && (cnt == si_cyc);
  wire hit_presence = (state == owc_pkg::OWC_RST_HIGH) && (cnt == msp_cyc);
  wire hit_bit = (state == owc_pkg::OWC_SLOT) && (cnt == msr_cyc);
  wire end_reset = (state == owc_pkg::OWC_RST_HIGH) && cnt_last_rst;
  wire end_slot = (state == owc_pkg::OWC_SLOT) && cnt_last_slot;
  // line is pulled low in reset-low and during the slot's low part
  wire next_drive_low = (state == owc_pkg::OWC_RST_LOW && !cnt_last_rst) ||
                        (state == owc_pkg::OWC_IDLE && cmd_taken) ||
                        (state == owc_pkg::OWC_SLOT && cnt < low_cyc - 20'h00001 && !cnt_last_slot);
  wire [2:0] events = {hit_short && !line_in, end_slot, end_reset};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= owc_pkg::OWC_IDLE;
      cnt <= 20'h00000;
      slot_bit <= 1'b1;
    end else begin
      unique case (state)
        owc_pkg::OWC_IDLE: begin
          cnt <= 20'h00000;
          // activity begins on the clock after acceptance, well inside the start delay
          if (start_reset) begin
            state <= owc_pkg::OWC_RST_LOW;
          end else if (start_bit) begin
            state <= owc_pkg::OWC_SLOT;
            slot_bit <= wr_data[owc_pkg::PARAM_BIT_POS];
          end
        end
        owc_pkg::OWC_RST_LOW: begin
          cnt <= cnt_last_rst ? 20'h00000 : cnt + 20'h00001;
          if (cnt_last_rst) begin
            state <= owc_pkg::OWC_RST_HIGH;
          end
        end
        owc_pkg::OWC_RST_HIGH: begin
          cnt <= cnt + 20'h00001;
          if (end_reset) begin
            state <= owc_pkg::OWC_IDLE;
          end
        end
        owc_pkg::OWC_SLOT: begin
          cnt <= cnt + 20'h00001;
          if (end_slot) begin
            state <= owc_pkg::OWC_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags and line pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_busy_flag <= 1'b0;
      presence_pulse_detected <= 1'b0;
      short_detected <= 1'b0;
      single_bit_result <= 1'b0;
      line_out <= 1'b0;
      line_oe <= 1'b0;
      strong_pullup_on <= 1'b0;
    end else begin
      if (cmd_taken) begin
        line_busy_flag <= 1'b1;
      end else if (end_reset || end_slot) begin
        line_busy_flag <= 1'b0;
      end
      if (hit_presence) begin
        presence_pulse_detected <= !line_in;
      end
      if (hit_short) begin
        short_detected <= !line_in;
      end
      if (hit_bit) begin
        single_bit_result <= line_in;
      end
      line_out <= 1'b0;
      line_oe <= next_drive_low;
      // strong pullup only where the line is released; misuse during reset is the host's burden
      strong_pullup_on <= config_bits[owc_pkg::CF_SPU] && !next_drive_low;
    end
  end

  // ----------------------------------------------------------------
  // software registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_bits <= owc_pkg::CONFIG_RESET;
      rstl_cyc <= RSTL_DEFAULT;
      msp_cyc <= MSP_DEFAULT;
      w0l_cyc <= W0L_DEFAULT;
      rec0_cyc <= REC0_DEFAULT;
      int_status <= 3'h0;
      int_mask <= 3'h0;
      read_ptr <= owc_pkg::ADDR_CONFIG;
      active_pullup_on <= 1'b0;
      pullup_pick_out <= 1'b0;
      overdrive_on <= 1'b0;
      irq <= 1'b0;
    end else begin
      // timing registers change only while idle so a running waveform stays consistent; config takes writes at any time
      if (wr_cfg) begin
        config_bits <= wr_data[3:0];
      end
      if (wr_rstl && !line_busy_flag) begin
        rstl_cyc <= wr_count;
      end
      if (wr_msp && !line_busy_flag) begin
        msp_cyc <= wr_count;
      end
      if (wr_w0l && !line_busy_flag) begin
        w0l_cyc <= wr_count;
      end
      if (wr_rec0 && !line_busy_flag) begin
        rec0_cyc <= wr_count;
      end
      // a new event wins over a simultaneous clear
      int_status <= (int_status & ~(wr_iclr ? wr_data[2:0] : 3'h0)) | events;
      if (wr_imask) begin
        int_mask <= wr_data[2:0];
      end
      if (cmd_taken) begin
        read_ptr <= owc_pkg::ADDR_STATUS;
      end
      active_pullup_on <= config_bits[owc_pkg::CF_APU];
      pullup_pick_out <= config_bits[owc_pkg::CF_PICK];
      overdrive_on <= od;
      irq <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [31:0] status_word = {26'h0000000, 1'b0, 1'b0, single_bit_result, short_detected,
                             presence_pulse_detected, line_busy_flag};
  wire [31:0] config_word = {28'h0000000, config_bits};
  wire [31:0] pointed_word = (read_ptr == owc_pkg::ADDR_STATUS) ? status_word : config_word;
  wire rd_mapped = (s_axi_araddr <= owc_pkg::ADDR_INT_MASK) && (s_axi_araddr[1:0] == 2'b00);
  wire [31:0] rd_word =
    (s_axi_araddr == owc_pkg::ADDR_STATUS) ? status_word :
    (s_axi_araddr == owc_pkg::ADDR_CONFIG) ? config_word :
    (s_axi_araddr == owc_pkg::ADDR_POINTED) ? pointed_word :
    (s_axi_araddr == owc_pkg::ADDR_RSTL) ? {12'h000, rstl_cyc} :
    (s_axi_araddr == owc_pkg::ADDR_MSP) ? {12'h000, msp_cyc} :
    (s_axi_araddr == owc_pkg::ADDR_W0L) ? {12'h000, w0l_cyc} :
    (s_axi_araddr == owc_pkg::ADDR_REC0) ? {12'h000, rec0_cyc} :
    (s_axi_araddr == owc_pkg::ADDR_INT_STATUS) ? {29'h00000000, int_status} :
    (s_axi_araddr == owc_pkg::ADDR_INT_MASK) ? {29'h00000000, int_mask} : 32'h00000000;

  // ----------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= owc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end
      // ready returns only after the response is taken, one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= owc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? owc_pkg::RESP_OKAY : owc_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
